// ==== rtl/tms_regs.vh ====
// Constants of the touch mode sequencer.
`ifndef TMS_REGS_VH
`define TMS_REGS_VH
`define TMS_SOFT_RESET_CODE   8'hde
`define TMS_OP_SELECT         4'h8
`define TMS_OP_CONVERT        4'h9
`define TMS_OP_MANUAL_AUTO_COMMAND        4'hb
`define TMS_OP_DETECT         4'hc
`define TMS_OP_TRIGGER        4'he
`define TMS_CHAN_SEQ          3'h7
`define TMS_NUM_CHAN          5
`define TMS_RATE_W            4
`define TMS_DLY_W             8
`define TMS_POR_CYCLES        16'h0040
`define TMS_RESET_HOLD        8'h04
`define TMS_RATE_UNIT_CYCLES  16'h0100
`define TMS_MODE_MANUAL       2'h0
`define TMS_MODE_AUTO         2'h1
`define TMS_MODE_DETECT       2'h2
`define TMS_MODE_TRIGGER      2'h3
`endif

// ==== rtl/tms_sync.v ====
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
`default_nettype none
module tms_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_n_in,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // tms_sync
`default_nettype wire

// ==== rtl/tms_sequencer.v ====
// Operating mode and reset sequencer of the touch controller.
`timescale 1ns/10ps
`default_nettype none
`include "tms_regs.vh"

// Functional notes
// - During power-up hold interrupt low, reset all state, ignore host traffic.
// - After power-up release, sit in manual mode with acquisition idle.
// - Writing soft reset code resets everything like the hardware reset pin.
// - Interrupt held low while hardware reset low, released once reset completes.
// - Manual/auto command picks manual at rate zero, automatic at nonzero rate outside touch modes.
// - Touch-detect mode senses touch, asserts interrupt and sets touch flag.
// - Touch-detect mode is left only by the manual mode command.
// - Touch-trigger mode converts on touch, then interrupts and sets conversion flag.
// - Touch-trigger mode is left only by the manual mode command.
// - Manual mode runs each command's task then idles.
// - Convert biases, waits settling delay, converts; select only biases.
// - Sequence code converts each masked channel with settling and bias removal.
// - Automatic mode acquires masked channels on touch and interrupts when done.
// - Automatic mode waits for full host read-out before next cycle.
// - Rate holds only if cycle time is below rate period.
// - Conditional bit set: new cycle and interrupt only on renewed touch.
// - Conditional bit clear: interrupt every cycle, mark invalid when untouched.
// - Conversion interrupt is released when the host reads channel data.
// - Touch flag clears when the host reads the status register.
// - Touch-trigger notifies only with touch and results, repeating as fast as possible.
// - Commands arriving while busy are discarded.
module tms_sequencer #(
    parameter NCHAN      = `TMS_NUM_CHAN,
    parameter POR_CYCLES = `TMS_POR_CYCLES,
    parameter RATE_UNIT  = `TMS_RATE_UNIT_CYCLES
) (
    // Clock and reset
    input  wire                   clk_in,
    input  wire                   rst_n_in,
    input  wire                   hard_reset_in_n,
    // Host command port (from SPI logic, same clock)
    input  wire                   cmd_valid_in,
    input  wire [7:0]             cmd_code_in,
    input  wire                   soft_reset_write_in,
    input  wire [7:0]             soft_reset_data_in,
    input  wire                   status_read_in,
    input  wire                   chan_read_done_in,
    // Configuration
    input  wire [`TMS_RATE_W-1:0] rate_in,
    input  wire [`TMS_DLY_W-1:0]  settling_delay_in,
    input  wire [NCHAN-1:0]       channel_mask_in,
    input  wire                   conditional_interrupt_bit_in,
    // Analog side
    input  wire                   touch_in,
    input  wire                   adc_done_in,
    output reg                    bias_en_out,
    output reg  [2:0]             bias_chan_out,
    output reg                    adc_start_out,
    output reg                    touch_sense_out,
    output reg                    data_invalid_out,
    // Status and host signals
    output reg                    interrupt_out_n,
    output reg                    touch_interrupt_flag_out,
    output reg                    conversion_interrupt_flag_out,
    output reg  [1:0]             mode_out,
    output reg                    busy_out,
    output reg                    spi_ready_out
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    wire [1:0] pins_sync;
    tms_sync #(.WIDTH(2)) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({hard_reset_in_n, touch_in}),
        .sync_out (pins_sync)
    );
    wire hard_rst_n = pins_sync[1];
    wire touch      = pins_sync[0];

    localparam S_RESET  = 3'h0;
    localparam S_IDLE   = 3'h1;
    localparam S_SETTLE = 3'h2;
    localparam S_CONV   = 3'h3;
    localparam S_WAIT   = 3'h4;
    localparam S_READ   = 3'h5;

    function [2:0] next_chan;
        input [NCHAN-1:0] mask;
        input [2:0]       from;
        integer k;
        begin
            next_chan = 3'h7;
            for (k = NCHAN - 1; k >= 0; k = k - 1)
                if (mask[k] && k >= from)
                    next_chan = k[2:0];
        end
    endfunction

    reg [15:0]            por_cnt_reg;
    reg [7:0]             hold_cnt_reg;
    reg [2:0]             state_reg;
    reg [`TMS_DLY_W-1:0]  dly_cnt_reg;
    reg [19:0]            rate_cnt_reg;
    reg                   seq_reg;
    reg                   soft_req_reg;
    reg                   touch_seen_reg;
    wire [19:0] rate_period = rate_in * RATE_UNIT[15:0];

    // ----------------------------------------------------------------
    // Reset handling
    // ----------------------------------------------------------------
    wire soft_hit = soft_reset_write_in && (soft_reset_data_in == `TMS_SOFT_RESET_CODE)
                    && state_reg != S_RESET;
    wire in_reset = (por_cnt_reg != 16'h0000) || (hold_cnt_reg != 8'h00);
    wire cmd_ok   = cmd_valid_in && !in_reset && (state_reg == S_IDLE || state_reg == S_WAIT);
    wire [3:0] op = cmd_code_in[7:4];
    wire manual_cmd = cmd_ok && op == `TMS_OP_MANUAL_AUTO_COMMAND && rate_in == {`TMS_RATE_W{1'b0}};

    // ----------------------------------------------------------------
    // Mode lock
    // ----------------------------------------------------------------
    wire mode_locked = mode_out[1];
    wire mode_cmd_ok = !mode_locked ||
                       (rate_in == {`TMS_RATE_W{1'b0}});

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            por_cnt_reg  <= POR_CYCLES[15:0];
            hold_cnt_reg <= 8'h00;
            soft_req_reg <= 1'b0;
        end
        else
        begin
            soft_req_reg <= soft_hit;
            if (por_cnt_reg != 16'h0000)
                por_cnt_reg <= por_cnt_reg - 16'h0001;
            if (!hard_rst_n || soft_req_reg)
                hold_cnt_reg <= `TMS_RESET_HOLD;
            else if (hold_cnt_reg != 8'h00)
                hold_cnt_reg <= hold_cnt_reg - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Mode and acquisition sequencer
    // ----------------------------------------------------------------
    always @(posedge clk_in)
    begin
        if (!rst_n_in || in_reset)
        begin
            state_reg                     <= S_RESET;
            mode_out                      <= `TMS_MODE_MANUAL;
            dly_cnt_reg                   <= {`TMS_DLY_W{1'b0}};
            rate_cnt_reg                  <= 20'h00000;
            seq_reg                       <= 1'b0;
            touch_seen_reg                <= 1'b0;
            bias_en_out                   <= 1'b0;
            bias_chan_out                 <= 3'h0;
            adc_start_out                 <= 1'b0;
            touch_sense_out               <= 1'b0;
            data_invalid_out              <= 1'b0;
            interrupt_out_n               <= 1'b0;
            touch_interrupt_flag_out      <= 1'b0;
            conversion_interrupt_flag_out <= 1'b0;
            busy_out                      <= 1'b1;
            spi_ready_out                 <= 1'b0;
        end
        else
        begin
            adc_start_out <= 1'b0;
            if (rate_cnt_reg != 20'h00000)
                rate_cnt_reg <= rate_cnt_reg - 20'h00001;
            if (status_read_in)
            begin
                touch_interrupt_flag_out <= 1'b0;
                if (!conversion_interrupt_flag_out)
                    interrupt_out_n <= 1'b1;
            end
            case (state_reg)
                S_RESET:
                begin
                    state_reg       <= S_IDLE;
                    interrupt_out_n <= 1'b1;
                    busy_out        <= 1'b0;
                    spi_ready_out   <= 1'b1;
                end
                S_IDLE:
                begin
                    touch_sense_out <= (mode_out != `TMS_MODE_MANUAL);
                    if (cmd_ok && (op == `TMS_OP_SELECT || op == `TMS_OP_CONVERT))
                    begin
                        seq_reg <= (cmd_code_in[2:0] == `TMS_CHAN_SEQ);
                        bias_chan_out <= (cmd_code_in[2:0] == `TMS_CHAN_SEQ) ?
                                         next_chan(channel_mask_in, 3'h0) : cmd_code_in[2:0];
                        bias_en_out <= 1'b1;
                        if (op == `TMS_OP_CONVERT &&
                            !(cmd_code_in[2:0] == `TMS_CHAN_SEQ && next_chan(channel_mask_in, 3'h0) == 3'h7))
                        begin
                            dly_cnt_reg <= settling_delay_in;
                            state_reg   <= S_SETTLE;
                            busy_out    <= 1'b1;
                        end
                    end
                    else if (cmd_ok && op == `TMS_OP_MANUAL_AUTO_COMMAND && mode_cmd_ok)
                    begin
                        mode_out <= (rate_in == {`TMS_RATE_W{1'b0}}) ? `TMS_MODE_MANUAL
                                                                      : `TMS_MODE_AUTO;
                        bias_en_out <= 1'b0;
                    end
                    else if (cmd_ok && op == `TMS_OP_DETECT && !mode_locked)
                        mode_out <= `TMS_MODE_DETECT;
                    else if (cmd_ok && op == `TMS_OP_TRIGGER && !mode_locked)
                        mode_out <= `TMS_MODE_TRIGGER;
                    else if (mode_out == `TMS_MODE_DETECT && touch && !touch_interrupt_flag_out)
                    begin
                        touch_interrupt_flag_out <= 1'b1;
                        interrupt_out_n          <= 1'b0;
                    end
                    else if (mode_out == `TMS_MODE_DETECT && !touch_interrupt_flag_out)
                        interrupt_out_n <= 1'b1;
                    else if (((mode_out == `TMS_MODE_TRIGGER && touch) ||
                              (mode_out == `TMS_MODE_AUTO && rate_cnt_reg == 20'h00000 &&
                               (touch || (!conditional_interrupt_bit_in && touch_seen_reg)) &&
                               !(conditional_interrupt_bit_in && touch_seen_reg && !touch)))
                             && next_chan(channel_mask_in, 3'h0) != 3'h7)
                    begin
                        seq_reg          <= 1'b1;
                        bias_chan_out    <= next_chan(channel_mask_in, 3'h0);
                        bias_en_out      <= 1'b1;
                        dly_cnt_reg      <= settling_delay_in;
                        rate_cnt_reg     <= rate_period;
                        data_invalid_out <= !touch;
                        touch_seen_reg   <= 1'b1;
                        state_reg        <= S_SETTLE;
                        busy_out         <= 1'b1;
                    end
                end
                S_SETTLE:
                begin
                    if (dly_cnt_reg == {`TMS_DLY_W{1'b0}})
                    begin
                        adc_start_out <= 1'b1;
                        state_reg     <= S_CONV;
                    end
                    else
                        dly_cnt_reg <= dly_cnt_reg - {{(`TMS_DLY_W-1){1'b0}}, 1'b1};
                end
                S_CONV:
                begin
                    if (adc_done_in)
                    begin
                        if (seq_reg && next_chan(channel_mask_in, bias_chan_out + 3'h1) != 3'h7
                            && bias_chan_out != 3'h7)
                        begin
                            bias_chan_out <= next_chan(channel_mask_in, bias_chan_out + 3'h1);
                            dly_cnt_reg   <= settling_delay_in;
                            state_reg     <= S_SETTLE;
                        end
                        else
                        begin
                            bias_en_out <= seq_reg ? 1'b0 : bias_en_out;
                            busy_out    <= 1'b0;
                            if (mode_out == `TMS_MODE_MANUAL)
                                state_reg <= S_IDLE;
                            else
                            begin
                                conversion_interrupt_flag_out <= 1'b1;
                                interrupt_out_n               <= 1'b0;
                                state_reg                     <= S_READ;
                            end
                        end
                    end
                end
                S_READ:
                begin
                    if (chan_read_done_in)
                    begin
                        conversion_interrupt_flag_out <= 1'b0;
                        interrupt_out_n               <= 1'b1;
                        state_reg                     <= S_WAIT;
                    end
                    else if (manual_cmd)
                        mode_out <= `TMS_MODE_MANUAL;
                end
                S_WAIT:
                begin
                    if (conditional_interrupt_bit_in && touch_seen_reg && !touch)
                        touch_seen_reg <= 1'b0;
                    state_reg <= S_IDLE;
                    if (manual_cmd)
                        mode_out <= `TMS_MODE_MANUAL;
                end
                default:
                    state_reg <= S_RESET;
            endcase
        end
    end
endmodule // tms_sequencer
`default_nettype wire

// ==== testbench/tms_seq_props.sv ====
// Assertion checker of the touch mode sequencer.
`timescale 1ns/10ps
`default_nettype none
module tms_seq_props (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       hard_reset_in_n,
    // Host side
    input wire logic       cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic       soft_reset_write_in,
    input wire logic       status_read_in,
    input wire logic [3:0] rate_in,
    input wire logic [7:0] settling_delay_in,
    input wire logic       touch_in,
    // Outputs
    input wire logic       adc_start_out,
    input wire logic       bias_en_out,
    input wire logic [2:0] bias_chan_out,
    input wire logic       interrupt_out_n,
    input wire logic       touch_interrupt_flag_out,
    input wire logic [1:0] mode_out,
    input wire logic       busy_out,
    input wire logic       spi_ready_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [8:0] cnt_reg;
    logic       one_reg;
    // Counts cycles since any convert was taken; one_reg marks a single-channel convert taken in manual mode.
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
            one_reg <= 1'b0;
        else if (cmd_valid_in && cmd_code_in[7:4] == 4'h9 && !busy_out && spi_ready_out && mode_out == 2'h0)
            one_reg <= (cmd_code_in[2:0] != 3'h7);
        else if (adc_start_out)
            one_reg <= 1'b0;
        if (cmd_valid_in && cmd_code_in[7:4] == 4'h9 && !busy_out && spi_ready_out)
            cnt_reg <= 9'h000;
        else
            cnt_reg <= cnt_reg + 9'h001;
    end
    sequence s_take(logic [3:0] op);
        cmd_valid_in && cmd_code_in[7:4] == op && !busy_out && spi_ready_out;
    endsequence
    property p_hrst; !hard_reset_in_n [*6] |-> !interrupt_out_n; endproperty
    a_hrst: assert property (p_hrst) else $error("irq high in hard reset");
    property p_mauto;
        s_take(4'hb) ##0 (rate_in == 4'h0 || !mode_out[1])
            |=> mode_out == (($past(rate_in) == 4'h0) ? 2'h0 : 2'h1);
    endproperty
    a_mauto: assert property (p_mauto) else $error("wrong mode after mode command");
    property p_conv;
        s_take(4'h9) ##0 (mode_out == 2'h0 && cmd_code_in[2:0] != 3'h7)
            |=> bias_en_out && bias_chan_out == $past(cmd_code_in[2:0]);
    endproperty
    a_conv: assert property (p_conv) else $error("convert did not bias channel");
    property p_dly; adc_start_out && one_reg && mode_out == 2'h0 |-> cnt_reg == {1'b0, settling_delay_in} + 9'h001; endproperty
    a_dly: assert property (p_dly) else $error("conversion start off settling time");
    property p_busy;
        busy_out && cmd_valid_in && spi_ready_out && !soft_reset_write_in
            |=> mode_out == $past(mode_out) || !spi_ready_out;
    endproperty
    a_busy: assert property (p_busy) else $error("command taken while busy");
    property p_stay;
        mode_out[1] && spi_ready_out && !soft_reset_write_in && !(cmd_valid_in && cmd_code_in[7:4] == 4'hb)
            |=> mode_out == $past(mode_out) || !spi_ready_out;
    endproperty
    a_stay: assert property (p_stay) else $error("touch mode left without mode command");
    property p_hold; !interrupt_out_n && mode_out[0] && spi_ready_out |-> !adc_start_out; endproperty
    a_hold: assert property (p_hold) else $error("conversion before read out");
    property p_stat; !touch_in [*4] ##0 (status_read_in && touch_interrupt_flag_out) |=> !touch_interrupt_flag_out; endproperty
    a_stat: assert property (p_stat) else $error("touch flag kept after status read");
endmodule // tms_seq_props
bind tms_sequencer tms_seq_props tms_seq_props_i (.*);
`default_nettype wire

// ==== testbench/tms_adc_model.sv ====
// Converter model answering each conversion start after a short or long time.
`timescale 1ns/10ps
`default_nettype none
module tms_adc_model (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Converter handshake
    input  wire logic adc_start_in,
    input  wire logic slow_in,
    output var  logic adc_done_out
);
    int cnt_reg;
    always @(posedge clk_in)
    begin
        adc_done_out <= 1'b0;
        if (!rst_n_in)
            cnt_reg <= 0;
        else if (adc_start_in)
            cnt_reg <= slow_in ? 9 : 2;
        else if (cnt_reg > 0)
        begin
            cnt_reg <= cnt_reg - 1;
            adc_done_out <= (cnt_reg == 1);
        end
    end
endmodule // tms_adc_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking testbench of the touch mode sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clk_in = 1'b0, rst_n_in = 1'b0, hard_reset_in_n = 1'b1, slow = 1'b0;
    logic       cmd_valid_in = 1'b0, soft_reset_write_in = 1'b0, status_read_in = 1'b0;
    logic       chan_read_done_in = 1'b0, conditional_interrupt_bit_in = 1'b1, touch_in = 1'b0;
    logic [7:0] cmd_code_in = 8'h00, soft_reset_data_in = 8'h00, settling_delay_in = 8'h03, lf = 8'h3a;
    logic [3:0] rate_in = 4'h0;
    logic [4:0] channel_mask_in = 5'h03;
    logic       adc_done_in, bias_en_out, adc_start_out, touch_sense_out, data_invalid_out;
    logic       interrupt_out_n, touch_interrupt_flag_out, conversion_interrupt_flag_out, busy_out, spi_ready_out;
    logic [2:0] bias_chan_out;
    logic [1:0] mode_out;
    int         bad_count = 0, n_checks = 0, exp_mode = 0, n_conv = 0, k, n0;
    tms_sequencer #(.POR_CYCLES(4), .RATE_UNIT(16)) tms_sequencer_i (.*);
    tms_adc_model tms_adc_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .adc_start_in(adc_start_out),
                                   .slow_in(slow), .adc_done_out(adc_done_in));
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) if (adc_start_out === 1'b1) n_conv <= n_conv + 1;
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wt(ref logic s, input logic v);
        for (k = 0; k < 3000 && s !== v; k++) tick(1);
        chk(s, v, "wait");
    endtask
    task automatic cmd(input logic [7:0] c);
        if (busy_out === 1'b0 && spi_ready_out === 1'b1)
        begin
            if (c[7:4] == 4'hb && (rate_in == 4'h0 || exp_mode < 2)) exp_mode = (rate_in == 4'h0) ? 0 : 1;
            else if (exp_mode < 2 && c[7:4] == 4'hc) exp_mode = 2;
            else if (exp_mode < 2 && c[7:4] == 4'he) exp_mode = 3;
        end
        cmd_code_in = c;
        pulse(cmd_valid_in);
    endtask
    task automatic mode(input logic [7:0] c);
        cmd(c);
        tick(1);
        chk(mode_out, exp_mode, "mode");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #(40 * 40000);
        bad_count++;
        wrap_up;
    end
    initial
    begin
        tick(2);
        rst_n_in = 1'b1;
        cmd(8'h91);
        chk({interrupt_out_n, bias_en_out}, 2'h0, "por");
        wt(spi_ready_out, 1'b1);
        chk({interrupt_out_n, bias_en_out, mode_out}, 4'h8, "idle");
        $display("power up done");
        for (int ch = 0; ch < 5; ch++)
        begin
            lf = nxt(lf);
            settling_delay_in = {3'h0, lf[4:0]};
            slow = lf[7];
            cmd(8'h90 | ch[7:0]);
            chk({bias_en_out, bias_chan_out}, {1'b1, ch[2:0]}, "bias");
            for (k = 0; k < 600 && adc_start_out !== 1'b1; k++) tick(1);
            chk(k, settling_delay_in + 1, "settle");
            cmd(8'hc0);
            wt(busy_out, 1'b0);
            chk(mode_out, 2'h0, "busy cmd");
        end
        n0 = n_conv;
        cmd(8'h82);
        tick(settling_delay_in + 4);
        chk({bias_en_out, bias_chan_out, n_conv[4:0] - n0[4:0]}, 9'h140, "select");
        cmd(8'h92);
        wt(busy_out, 1'b0);
        chk({bias_en_out, bias_chan_out}, 4'ha, "select then convert");
        lf = nxt(lf);
        channel_mask_in = lf[4:0] | 5'h01;
        n0 = n_conv;
        cmd(8'h97);
        wt(busy_out, 1'b0);
        chk(n_conv - n0, $countones(channel_mask_in), "seq count");
        chk(bias_en_out, 1'b0, "seq bias");
        $display("manual done");
        mode(8'hc0);
        chk(touch_sense_out, 1'b1, "sense");
        touch_in = 1'b1;
        wt(interrupt_out_n, 1'b0);
        chk(touch_interrupt_flag_out, 1'b1, "touch flag");
        mode(8'he0);
        touch_in = 1'b0;
        tick(5);
        pulse(status_read_in);
        chk(touch_interrupt_flag_out, 1'b0, "flag clear");
        mode(8'hb0);
        mode(8'he0);
        n0 = n_conv;
        touch_in = 1'b1;
        wt(interrupt_out_n, 1'b0);
        chk(conversion_interrupt_flag_out, 1'b1, "conv flag");
        chk(n_conv - n0, $countones(channel_mask_in), "trig count");
        touch_in = 1'b0;
        tick(4);
        pulse(chan_read_done_in);
        tick(1);
        chk(interrupt_out_n, 1'b1, "release");
        tick(30);
        chk(interrupt_out_n, 1'b1, "no touch");
        mode(8'hb0);
        $display("touch modes done");
        rate_in = 4'h1;
        mode(8'hb0);
        n0 = n_conv;
        touch_in = 1'b1;
        wt(interrupt_out_n, 1'b0);
        tick(40);
        chk(n_conv - n0, $countones(channel_mask_in), "auto hold");
        pulse(chan_read_done_in);
        wt(interrupt_out_n, 1'b0);
        touch_in = 1'b0;
        conditional_interrupt_bit_in = 1'b0;
        tick(4);
        pulse(chan_read_done_in);
        wt(interrupt_out_n, 1'b0);
        chk(data_invalid_out, 1'b1, "invalid");
        conditional_interrupt_bit_in = 1'b1;
        pulse(chan_read_done_in);
        tick(40);
        chk(interrupt_out_n, 1'b1, "cond irq");
        rate_in = 4'h0;
        mode(8'hb0);
        $display("auto done");
        soft_reset_data_in = 8'h5a;
        pulse(soft_reset_write_in);
        tick(2);
        chk(spi_ready_out, 1'b1, "bad code");
        mode(8'hc0);
        soft_reset_data_in = 8'hde;
        pulse(soft_reset_write_in);
        tick(2);
        chk(spi_ready_out, 1'b0, "soft");
        wt(spi_ready_out, 1'b1);
        exp_mode = 0;
        chk({interrupt_out_n, mode_out}, 3'h4, "soft idle");
        hard_reset_in_n = 1'b0;
        tick(6);
        chk(interrupt_out_n, 1'b0, "hard");
        hard_reset_in_n = 1'b1;
        wt(interrupt_out_n, 1'b1);
        chk(mode_out, 2'h0, "hard idle");
        $display("resets done");
        wrap_up;
    end
endmodule // tb
`default_nettype wire
